/* File: shared/difeu_pkg.sv */
package difeu_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PEND_LO  = 8'h00;
  localparam logic [7:0] OFS_ENA_LO   = 8'h04;
  localparam logic [7:0] OFS_DPEND_LO = 8'h08;
  localparam logic [7:0] OFS_DENA_LO  = 8'h0c;
  localparam logic [7:0] OFS_PEND_HI  = 8'h10;
  localparam logic [7:0] OFS_ENA_HI   = 8'h14;
  localparam logic [7:0] OFS_DPEND_HI = 8'h18;
  localparam logic [7:0] OFS_DENA_HI  = 8'h1c;
  localparam logic [7:0] OFS_STATUS   = 8'h20;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_REG16   = 16'h0000;
  localparam logic [15:0] RW_MASK_LO  = 16'hfffc;
  localparam logic [15:0] RW_MASK_HI  = 16'h07ff;
  localparam logic [31:0] SRC_MASK    = 32'h07ff_fefc;
  localparam int          SLOT_WDT    = 11;
  localparam int          SLOT_UART   = 12;
  localparam int          NUM_SLOTS   = 32;
  localparam logic [7:0]  LOC_STEP    = 8'h08;
  localparam int          STAT_VALID  = 31;

  // external request slots: external_request_0, external_request_1, external_request_2, int3, external_request_4
  localparam int EXT_SLOT [5] = '{2, 16, 3, 11, 19};
  localparam logic [3:0] EXT_DETECT = 4'h8;

  // fixed priority per vector slot, independent of location
  localparam logic [4:0] SLOT_PRIO [NUM_SLOTS] = '{
    5'h00, 5'h01, 5'h03, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0a,
    5'h0b, 5'h0d, 5'h0e, 5'h0f, 5'h11, 5'h12, 5'h15, 5'h16,
    5'h04, 5'h08, 5'h0c, 5'h10, 5'h13, 5'h14, 5'h17, 5'h18,
    5'h02, 5'h19, 5'h1a, 5'h1b, 5'h1c, 5'h1d, 5'h1e, 5'h1f};

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [4:0] slot;
    logic [7:0] location;
    logic [4:0] priority_num;
  } difeu_vec_s;

  typedef struct packed {
    logic [31:0] pend;
    logic [31:0] ena;
    logic [31:0] dena;
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic [19:0] hist;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    difeu_vec_s  vec;
    logic        ack_n;
  } difeu_state_s;

endpackage

/* File: core/difeu_top.sv */
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module difeu_top (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [31:0]         periph_req,
  input  wire logic                external_request_0,
  input  wire logic                external_request_1,
  input  wire logic                external_request_2,
  input  wire logic                external_request_3,
  input  wire logic                external_request_4,
  input  wire logic                watchdog_request,
  input  wire logic                watchdog_routed,
  input  wire logic                uart_request,
  input  wire logic                cpu_halted_rt,
  input  wire logic                soft_reset,
  input  wire logic                vector_fetch,
  input  wire logic [4:0]          vector_fetch_slot,
  output difeu_pkg::difeu_vec_s    irq_vec,
  output logic                     acknowledge_output_n
);
  import difeu_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic addr_mapped(input logic [7:0] a);
    unique case (a)
      OFS_PEND_LO, OFS_ENA_LO, OFS_DPEND_LO, OFS_DENA_LO,
      OFS_PEND_HI, OFS_ENA_HI, OFS_DPEND_HI, OFS_DENA_HI,
      OFS_STATUS: addr_mapped = 1'b1;
      default:    addr_mapped = 1'b0;
    endcase
  endfunction

  // merge a 16-bit software write into one half of a 32-bit set
  function automatic logic [31:0] wr_half(input logic [31:0] cur,
                                          input logic        hi,
                                          input logic [15:0] val);
    logic [31:0] r;
    r = cur;
    if (hi) begin
      r[31:16] = val & RW_MASK_HI;
    end else begin
      r[15:0] = val & RW_MASK_LO;
    end
    wr_half = r;
  endfunction

  difeu_state_s s_r;
  difeu_state_s s_nxt;

  logic [4:0]  ext_in;
  logic [31:0] hw_set;
  logic [31:0] eff_ena;
  logic [31:0] live;
  logic        wr_acc;
  logic        pick_v;
  logic [4:0]  pick_slot;
  logic [4:0]  pick_prio;
  logic [15:0] wval;
  logic [31:0] dpend;

  assign ext_in = {external_request_4, external_request_3,
                   external_request_2, external_request_1,
                   external_request_0};

  always_comb begin
    s_nxt   = s_r;
    hw_set  = '0;
    wval    = pwdata[15:0];
    wr_acc  = psel & penable & s_r.pready & pwrite;

    // ---------------------------------------------------------------
    // external request qualification
    // ---------------------------------------------------------------
    // two flop sync
    s_nxt.sync1 = ext_in;
    s_nxt.sync2 = s_r.sync1;
    for (int i = 0; i < 5; i++) begin
      s_nxt.hist[i*4 +: 4] = {s_r.hist[i*4 +: 3], s_r.sync2[i]};
      if (s_r.hist[i*4 +: 4] == EXT_DETECT) begin
        hw_set[EXT_SLOT[i]] = 1'b1;
      end
    end

    // ---------------------------------------------------------------
    // peripheral sources
    // ---------------------------------------------------------------
    // pending set per source
    hw_set = hw_set | periph_req;
    if (watchdog_request && watchdog_routed) begin
      hw_set[SLOT_WDT] = 1'b1;
    end
    if (uart_request) begin
      hw_set[SLOT_UART] = 1'b1;
    end
    hw_set = hw_set & SRC_MASK;

    // ---------------------------------------------------------------
    // flag register update
    // ---------------------------------------------------------------
    if (wr_acc && paddr == OFS_PEND_LO) begin
      s_nxt.pend = wr_half(s_r.pend, 1'b0, wval);
    end
    if (wr_acc && paddr == OFS_PEND_HI) begin
      s_nxt.pend = wr_half(s_r.pend, 1'b1, wval);
    end
    if (soft_reset) begin
      s_nxt.pend = '0;
    end
    s_nxt.ack_n = 1'b1;
    if (vector_fetch) begin
      s_nxt.pend[vector_fetch_slot] = 1'b0;
      s_nxt.ack_n = 1'b0;
    end
    // an arriving event beats any clear in the same cycle
    s_nxt.pend = s_nxt.pend | hw_set;

    // ---------------------------------------------------------------
    // mask registers
    // ---------------------------------------------------------------
    if (wr_acc && paddr == OFS_ENA_LO) begin
      s_nxt.ena = wr_half(s_r.ena, 1'b0, wval);
    end
    if (wr_acc && paddr == OFS_ENA_HI) begin
      s_nxt.ena = wr_half(s_r.ena, 1'b1, wval);
    end
    if (wr_acc && paddr == OFS_DENA_LO) begin
      s_nxt.dena = wr_half(s_r.dena, 1'b0, wval);
    end
    if (wr_acc && paddr == OFS_DENA_HI) begin
      s_nxt.dena = wr_half(s_r.dena, 1'b1, wval);
    end

    // ---------------------------------------------------------------
    // arbitration
    // ---------------------------------------------------------------
    // effective enable
    eff_ena = cpu_halted_rt ? (s_r.ena & s_r.dena) : s_r.ena;
    live    = s_r.pend & eff_ena & SRC_MASK;
    pick_v    = 1'b0;
    pick_slot = '0;
    pick_prio = '1;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (live[i] && (!pick_v || SLOT_PRIO[i] < pick_prio)) begin
        pick_v    = 1'b1;
        pick_slot = 5'(i);
        pick_prio = SLOT_PRIO[i];
      end
    end
    // the fetched slot is dropped at once so it is not offered twice
    if (vector_fetch && pick_slot == vector_fetch_slot) begin
      pick_v = 1'b0;
    end
    s_nxt.vec.valid        = pick_v;
    s_nxt.vec.slot         = pick_slot;
    s_nxt.vec.location     = 8'({pick_slot, 3'b000});
    s_nxt.vec.priority_num = pick_prio;

    // ---------------------------------------------------------------
    // apb slave: no wait state, answer in the first access cycle
    // ---------------------------------------------------------------
    dpend = s_r.pend & s_r.dena;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    if (psel && !penable) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = !addr_mapped(paddr);
      s_nxt.prdata  = '0;
      unique case (paddr)
        OFS_PEND_LO:  s_nxt.prdata[15:0] = s_r.pend[15:0];
        OFS_ENA_LO:   s_nxt.prdata[15:0] = s_r.ena[15:0];
        OFS_DPEND_LO: s_nxt.prdata[15:0] = dpend[15:0];
        OFS_DENA_LO:  s_nxt.prdata[15:0] = s_r.dena[15:0];
        OFS_PEND_HI:  s_nxt.prdata[15:0] = s_r.pend[31:16];
        OFS_ENA_HI:   s_nxt.prdata[15:0] = s_r.ena[31:16];
        OFS_DPEND_HI: s_nxt.prdata[15:0] = dpend[31:16];
        OFS_DENA_HI:  s_nxt.prdata[15:0] = s_r.dena[31:16];
        OFS_STATUS: begin
          s_nxt.prdata[STAT_VALID] = s_r.vec.valid;
          s_nxt.prdata[17:0] = {s_r.vec.slot, s_r.vec.location,
                                s_r.vec.priority_num};
        end
        default: s_nxt.prdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r       <= '0;
      s_r.pend  <= {RST_REG16, RST_REG16};
      s_r.ena   <= {RST_REG16, RST_REG16};
      s_r.dena  <= {RST_REG16, RST_REG16};
      s_r.ack_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata               = s_r.prdata;
  assign pready               = s_r.pready;
  assign pslverr              = s_r.pslverr;
  assign irq_vec              = s_r.vec;
  assign acknowledge_output_n = s_r.ack_n;

endmodule // difeu_top

`default_nettype wire

/* File: tb/difeu_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module difeu_checker
  import difeu_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] periph_req,
  input wire logic        uart_request,
  input wire logic        watchdog_request,
  input wire logic        soft_reset,
  input wire logic        vector_fetch,
  input wire difeu_vec_s  irq_vec,
  input wire logic        acknowledge_output_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------
  // bus and vector checks
  // ---------------------------------------------------------------
  ready_once_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle");
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h20
    |=> pslverr && prdata == 32'h0) else $error("no error on unmapped");
  ack_pulse_a: assert property (
    vector_fetch |=> !acknowledge_output_n ##1 acknowledge_output_n)
    else $error("acknowledge pulse wrong");
  ack_cause_a: assert property (
    $fell(acknowledge_output_n) |-> $past(vector_fetch))
    else $error("acknowledge without fetch");
  vec_location_a: assert property (
    irq_vec.valid |-> irq_vec.location == {irq_vec.slot, 3'b000})
    else $error("vector location wrong");
  prio_dma_os_a: assert property (irq_vec.valid |->
    (irq_vec.slot != 5'd9 || irq_vec.priority_num == 5'd13) &&
    (irq_vec.slot != 5'd26 || irq_vec.priority_num == 5'd26))
    else $error("dma or os priority wrong");
  prio_xmit_a: assert property (irq_vec.valid &&
    irq_vec.slot == 5'd17 |-> irq_vec.priority_num == 5'd8)
    else $error("transmit priority wrong");
  prio_shared_a: assert property (irq_vec.valid |->
    (irq_vec.slot != 5'd11 || irq_vec.priority_num == 5'd15) &&
    (irq_vec.slot != 5'd12 || irq_vec.priority_num == 5'd17))
    else $error("shared slot priority wrong");
  // flags set in the same cycle would win, so quiet sources only
  soft_clear_a: assert property (soft_reset && !uart_request &&
    !watchdog_request && periph_req == 32'h0 |=> ##1 !irq_vec.valid)
    else $error("soft reset left a vector");
  cover property (vector_fetch);
  cover property (pslverr);
  cover property (soft_reset);
endmodule // difeu_checker
bind difeu_top difeu_checker u_chk (.*);
`default_nettype wire

/* File: tb/difeu_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module difeu_cpu_model
  import difeu_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       fetch_en,
  input  wire logic [1:0] dly,
  input  wire difeu_vec_s irq_vec,
  output logic            vector_fetch,
  output logic [4:0]      vector_fetch_slot
);
  logic [2:0] hold_r;
  // ---------------------------------------------------------------
  // fetch the presented vector; hold-off lets the flag clear land
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_fetch <= 1'b0;
      vector_fetch_slot <= 5'h00;
      hold_r <= 3'h0;
    end else begin
      vector_fetch <= 1'b0;
      if (hold_r != 3'h0) begin
        hold_r <= hold_r - 3'h1;
      end else if (fetch_en && irq_vec.valid) begin
        vector_fetch <= 1'b1;
        vector_fetch_slot <= irq_vec.slot;
        hold_r <= 3'h3 + {1'b0, dly};
      end
    end
  end
endmodule // difeu_cpu_model
`default_nettype wire

/* File: tb/difeu_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module difeu_top_tb;
  import difeu_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, wdog, routed, uart;
  logic halt, srst, fen;
  logic [7:0] paddr;
  logic [31:0] pwdata, periph_req, prdata;
  logic [4:0] ext_n, vslot;
  logic [1:0] dly;
  logic pready, pslverr, vf, ack_n;
  difeu_vec_s irq_vec;
  logic [32:0] rq[$];
  int fq[$];
  int error_cnt, check_count, cyc, s;
  int xs[5] = '{2, 16, 3, 11, 19};
  difeu_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_req(periph_req), .external_request_0(ext_n[0]),
    .external_request_1(ext_n[1]), .external_request_2(ext_n[2]),
    .external_request_3(ext_n[3]), .external_request_4(ext_n[4]),
    .watchdog_request(wdog), .watchdog_routed(routed),
    .uart_request(uart), .cpu_halted_rt(halt), .soft_reset(srst),
    .vector_fetch(vf), .vector_fetch_slot(vslot), .irq_vec(irq_vec),
    .acknowledge_output_n(ack_n));
  difeu_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .fetch_en(fen),
    .dly(dly), .irq_vec(irq_vec), .vector_fetch(vf),
    .vector_fetch_slot(vslot));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic err = 1'b0);
    rq.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic raise(input logic [31:0] m, input logic w, input logic u);
    periph_req <= m;
    wdog <= w;
    uart <= u;
    @(posedge pclk);
    periph_req <= 32'h0;
    wdog <= 1'b0;
    uart <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic drain();
    for (int i = 0; i < 100 && fq.size() != 0; i++) @(posedge pclk);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // clock, monitors, timeout
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0)
      chk({pslverr, prdata}, rq.pop_front());
    if (vf === 1'b1)
      chk(33'(vslot), fq.size() ? 33'(fq.pop_front()) : 33'h100);
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, wdog, routed, uart} = '0;
    {halt, srst, fen, paddr, pwdata, periph_req, dly} = '0;
    ext_n = '1;
    void'($urandom(32'h11ec3906));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0);
    rd(8'h40, 32'h0, 1'b1);
    apb(1'b1, OFS_ENA_LO, 32'hffff);
    apb(1'b1, OFS_ENA_HI, 32'hffff);
    apb(1'b1, OFS_DPEND_LO, 32'hffff);
    rd(OFS_ENA_LO, 32'hfffc);
    rd(OFS_ENA_HI, 32'h07ff);
    rd(OFS_DPEND_LO, 32'h0);
    fen <= 1'b1;
    // some slots may be drawn twice, which is harmless
    for (int i = 0; i < 8; i++) begin
      s = $urandom_range(2, 26);
      dly <= 2'($urandom);
      if (SRC_MASK[s]) begin
        fq.push_back(s);
        raise(32'h1 << s, 1'b0, 1'b0);
        drain();
      end
    end
    fq = '{24, 17, 9, 14};
    raise(32'h0102_4200, 1'b0, 1'b0);
    drain();
    raise(32'h0, 1'b1, 1'b0);
    rd(OFS_PEND_LO, 32'h0);
    routed <= 1'b1;
    fq = '{11, 12};
    raise(32'h0, 1'b1, 1'b0);
    raise(32'h0, 1'b0, 1'b1);
    drain();
    apb(1'b1, OFS_ENA_LO, 32'h0);
    raise(32'h200, 1'b0, 1'b0);
    rd(OFS_PEND_LO, 32'h200);
    srst <= 1'b1;
    @(posedge pclk);
    srst <= 1'b0;
    @(posedge pclk);
    rd(OFS_PEND_LO, 32'h0);
    rd(OFS_ENA_HI, 32'h07ff);
    apb(1'b1, OFS_ENA_LO, 32'hffff);
    apb(1'b1, OFS_DENA_LO, 32'h0);
    halt <= 1'b1;
    raise(32'h200, 1'b0, 1'b0);
    rd(OFS_PEND_LO, 32'h200);
    fq.push_back(9);
    apb(1'b1, OFS_DENA_LO, 32'h200);
    drain();
    halt <= 1'b0;
    // two low samples only: must not be taken
    ext_n[0] <= 1'b0;
    repeat (2) @(posedge pclk);
    ext_n[0] <= 1'b1;
    // let the short pulse settle before the next pin falls
    repeat (6) @(posedge pclk);
    rd(OFS_PEND_LO, 32'h0);
    for (int i = 0; i < 5; i++) begin
      fq.push_back(xs[i]);
      ext_n[i] <= 1'b0;
      repeat (6) @(posedge pclk);
      ext_n[i] <= 1'b1;
      drain();
    end
    chk(33'(fq.size()), 33'h0);
    print_verdict();
  end
endmodule // difeu_top_tb
`default_nettype wire
